// ---- rtl/lsc_defines.vh ----
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

`define LSC_ADDR_W 5
`define LSC_DATA_W 16
`define LSC_LANES 4
`define LSC_DRIVE_ADDR 5'h07
`define LSC_RECV_ADDR 5'h08
`define LSC_DRIVE_RST 16'hDC04
`define LSC_RECV_RST 16'h0001

`define LSC_SWING_MSB 14
`define LSC_SWING_LSB 12
`define LSC_LOS_BIT 11
`define LSC_RXON_BIT 10
`define LSC_RXRATE_MSB 9
`define LSC_RXRATE_LSB 8
`define LSC_DE_MSB 7
`define LSC_DE_LSB 4
`define LSC_TXON_BIT 2
`define LSC_TXRATE_MSB 1
`define LSC_TXRATE_LSB 0

`define LSC_TXINV_BIT 15
`define LSC_RXINV_BIT 14
`define LSC_EQ_MSB 11
`define LSC_EQ_LSB 8
`define LSC_CDR_MSB 6
`define LSC_CDR_LSB 4
`define LSC_INTEST_BIT 3
`define LSC_OUTTEST_BIT 2

`define LSC_RATE_FULL 2'h0
`define LSC_RATE_HALF 2'h1
`define LSC_RATE_QUARTER 2'h2
`define LSC_RATE_RSVD 2'h3
`define LSC_EQ_MAXGAIN 4'h0
`define LSC_EQ_STEP_BIT 3
`define LSC_CDR_RSVD_PFX 2'h3
`define LSC_LPBK_OFF 2'h0
`define LSC_UPPER_LANE_MASK 4'hC

`endif

// ---- rtl/lsc_lane_regs.v ----
`timescale 1ns/1ps
`include "lsc_defines.vh"

// Private copy of both configuration words for one lane
module lsc_lane_regs #(
  parameter DATA_W = `LSC_DATA_W,
  parameter [DATA_W-1:0] DRIVE_RST = `LSC_DRIVE_RST,
  parameter [DATA_W-1:0] RECV_RST = `LSC_RECV_RST
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire drive_we_i,
  input wire recv_we_i,
  input wire [DATA_W-1:0] wdata_i,
  output wire [DATA_W-1:0] drive_o,
  output wire [DATA_W-1:0] recv_o
);

  reg [DATA_W-1:0] drive_q;
  reg [DATA_W-1:0] recv_q;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drive_q <= DRIVE_RST;
      recv_q <= RECV_RST;
    end
    else
    begin
      if (drive_we_i)
      begin
        drive_q <= wdata_i;
      end
      if (recv_we_i)
      begin
        recv_q <= wdata_i;
      end
    end
  end

  assign drive_o = drive_q;
  assign recv_o = recv_q;

endmodule

// ---- rtl/lsc_top.v ----
`timescale 1ns/1ps
`include "lsc_defines.vh"

// Low-side lane configuration bank: per-lane storage, read mux and lane control decode
module lsc_top #(
  parameter LANES = `LSC_LANES,
  parameter ADDR_W = `LSC_ADDR_W,
  parameter DATA_W = `LSC_DATA_W
) (
  input wire clk_i,
  input wire rst_n_i,
  // Register port from the management frame decoder
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [DATA_W-1:0] reg_wdata_i,
  output wire [DATA_W-1:0] reg_rdata_o,
  output wire reg_hit_o,
  output wire sel_valid_o,
  // Lane selector and channel-level controls from neighbouring registers
  input wire [LANES-1:0] lane_select_onehot_i,
  input wire ctrl_powerdown_i,
  input wire ser_2to1_mode_i,
  input wire deser_1to2_mode_i,
  input wire [1:0] far_loopback_select_i,
  // Channel power-down pin, asynchronous
  input wire channel_powerdown_n_i,
  // Per-lane controls to the analog lanes
  output wire [3*LANES-1:0] tx_amplitude_code_o,
  output wire [LANES-1:0] sig_loss_detect_en_o,
  output wire [LANES-1:0] rx_lane_on_o,
  output wire [2*LANES-1:0] rx_lane_speed_o,
  output wire [LANES-1:0] rx_speed_reserved_o,
  output wire [4*LANES-1:0] tx_deemph_code_o,
  output wire [LANES-1:0] tx_lane_on_o,
  output wire [2*LANES-1:0] tx_lane_speed_o,
  output wire [LANES-1:0] tx_speed_reserved_o,
  output wire [LANES-1:0] tx_polarity_swap_o,
  output wire [LANES-1:0] rx_polarity_swap_o,
  output wire [4*LANES-1:0] rx_equalizer_code_o,
  output wire [LANES-1:0] rx_eq_max_gain_o,
  output wire [3*LANES-1:0] rx_eq_zero_step_o,
  output wire [LANES-1:0] rx_eq_reserved_o,
  output wire [LANES-1:0] cdr_second_order_o,
  output wire [LANES-1:0] cdr_low_precision_o,
  output wire [LANES-1:0] cdr_threshold17_o,
  output wire [LANES-1:0] cdr_reserved_o,
  output wire [LANES-1:0] input_side_test_on_o,
  output wire [LANES-1:0] output_side_test_on_o,
  output wire [LANES-1:0] far_loopback_on_o
);

  // Power-down pin synchroniser
  reg pd_meta_q;
  reg pd_sync_q;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
    end
    else
    begin
      pd_meta_q <= channel_powerdown_n_i;
      pd_sync_q <= pd_meta_q;
    end
  end

  // Channel held down by the pin or by the control bit
  wire chan_down;
  assign chan_down = ~pd_sync_q | ctrl_powerdown_i;

  // Address decode
  wire hit_drive;
  wire hit_recv;
  assign hit_drive = (reg_addr_i == `LSC_DRIVE_ADDR);
  assign hit_recv = (reg_addr_i == `LSC_RECV_ADDR);
  assign reg_hit_o = hit_drive | hit_recv;

  // One-hot check on the selector
  wire sel_onehot;
  assign sel_onehot = (lane_select_onehot_i != {LANES{1'b0}}) &&
    ((lane_select_onehot_i & (lane_select_onehot_i - 1'b1)) == {LANES{1'b0}});
  assign sel_valid_o = sel_onehot;

  wire [DATA_W*LANES-1:0] drive_all;
  wire [DATA_W*LANES-1:0] recv_all;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : lane
      wire [DATA_W-1:0] drv;
      wire [DATA_W-1:0] rcv;

      lsc_lane_regs #(
        .DATA_W(DATA_W)
      ) u_regs (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .drive_we_i(reg_wr_i & hit_drive & lane_select_onehot_i[g]),
        .recv_we_i(reg_wr_i & hit_recv & lane_select_onehot_i[g]),
        .wdata_i(reg_wdata_i),
        .drive_o(drv),
        .recv_o(rcv)
      );

      assign drive_all[g*DATA_W +: DATA_W] = drv;
      assign recv_all[g*DATA_W +: DATA_W] = rcv;

      // Upper lane pair is unused in the narrow serdes ratios
      wire upper_lane;
      assign upper_lane = |(`LSC_UPPER_LANE_MASK & (4'h1 << g));

      // Field extraction
      wire [2:0] swing;
      wire los_en;
      wire rx_en;
      wire [1:0] rx_rate;
      wire [3:0] deemph;
      wire tx_en;
      wire [1:0] tx_rate;
      wire tx_inv;
      wire rx_inv;
      wire [3:0] eq;
      wire [2:0] cdr;
      wire in_test;
      wire out_test;
      assign swing = drv[`LSC_SWING_MSB:`LSC_SWING_LSB];
      assign los_en = drv[`LSC_LOS_BIT];
      assign rx_en = drv[`LSC_RXON_BIT];
      assign rx_rate = drv[`LSC_RXRATE_MSB:`LSC_RXRATE_LSB];
      assign deemph = drv[`LSC_DE_MSB:`LSC_DE_LSB];
      assign tx_en = drv[`LSC_TXON_BIT];
      assign tx_rate = drv[`LSC_TXRATE_MSB:`LSC_TXRATE_LSB];
      assign tx_inv = rcv[`LSC_TXINV_BIT];
      assign rx_inv = rcv[`LSC_RXINV_BIT];
      assign eq = rcv[`LSC_EQ_MSB:`LSC_EQ_LSB];
      assign cdr = rcv[`LSC_CDR_MSB:`LSC_CDR_LSB];
      assign in_test = rcv[`LSC_INTEST_BIT];
      assign out_test = rcv[`LSC_OUTTEST_BIT];

      // Decoded lane controls, next values
      reg rx_on_d;
      reg tx_on_d;
      reg [1:0] rx_spd_d;
      reg rx_rsv_d;
      reg [1:0] tx_spd_d;
      reg tx_rsv_d;
      reg eq_max_d;
      reg [2:0] eq_step_d;
      reg eq_rsv_d;
      reg cdr_2nd_d;
      reg cdr_lowp_d;
      reg cdr_t17_d;
      reg cdr_rsv_d;

      always @*
      begin
        rx_on_d = rx_en & ~chan_down & ~(ser_2to1_mode_i & upper_lane);
        tx_on_d = tx_en & ~chan_down & ~(deser_1to2_mode_i & upper_lane);
        // Reserved rate codes, and the quarter-rate code on the transmit side, fall back to full rate and raise a flag
        rx_rsv_d = (rx_rate == `LSC_RATE_RSVD);
        rx_spd_d = rx_rsv_d ? `LSC_RATE_FULL : rx_rate;
        tx_rsv_d = (tx_rate == `LSC_RATE_RSVD) || (tx_rate == `LSC_RATE_QUARTER);
        tx_spd_d = tx_rsv_d ? `LSC_RATE_FULL : tx_rate;
        // Equalizer: max gain, stepped zero frequency, or reserved
        eq_max_d = (eq == `LSC_EQ_MAXGAIN);
        eq_rsv_d = ~eq[`LSC_EQ_STEP_BIT] & ~eq_max_d;
        eq_step_d = eq[`LSC_EQ_STEP_BIT] ? eq[2:0] : 3'h0;
        // Clock recovery loop mode decode
        cdr_rsv_d = 1'b0;
        cdr_2nd_d = 1'b0;
        cdr_lowp_d = 1'b0;
        cdr_t17_d = 1'b0;
        case (cdr)
          3'h0:
          begin
            cdr_t17_d = 1'b0;
          end
          3'h1:
          begin
            cdr_t17_d = 1'b1;
          end
          3'h2:
          begin
            cdr_2nd_d = 1'b1;
          end
          3'h3:
          begin
            cdr_2nd_d = 1'b1;
            cdr_t17_d = 1'b1;
          end
          3'h4:
          begin
            cdr_lowp_d = 1'b1;
          end
          3'h5:
          begin
            cdr_2nd_d = 1'b1;
            cdr_lowp_d = 1'b1;
            cdr_t17_d = 1'b1;
          end
          default:
          begin
            cdr_rsv_d = 1'b1;
          end
        endcase
      end

      // Registered lane controls
      reg [2:0] swing_q;
      reg los_q;
      reg rx_on_q;
      reg [1:0] rx_spd_q;
      reg rx_rsv_q;
      reg [3:0] de_q;
      reg tx_on_q;
      reg [1:0] tx_spd_q;
      reg tx_rsv_q;
      reg tx_inv_q;
      reg rx_inv_q;
      reg [3:0] eq_q;
      reg eq_max_q;
      reg [2:0] eq_step_q;
      reg eq_rsv_q;
      reg cdr_2nd_q;
      reg cdr_lowp_q;
      reg cdr_t17_q;
      reg cdr_rsv_q;
      reg in_test_q;
      reg out_test_q;
      reg lpbk_q;

      always @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          swing_q <= 3'h0;
          los_q <= 1'b0;
          rx_on_q <= 1'b0;
          rx_spd_q <= 2'h0;
          rx_rsv_q <= 1'b0;
          de_q <= 4'h0;
          tx_on_q <= 1'b0;
          tx_spd_q <= 2'h0;
          tx_rsv_q <= 1'b0;
          tx_inv_q <= 1'b0;
          rx_inv_q <= 1'b0;
          eq_q <= 4'h0;
          eq_max_q <= 1'b0;
          eq_step_q <= 3'h0;
          eq_rsv_q <= 1'b0;
          cdr_2nd_q <= 1'b0;
          cdr_lowp_q <= 1'b0;
          cdr_t17_q <= 1'b0;
          cdr_rsv_q <= 1'b0;
          in_test_q <= 1'b0;
          out_test_q <= 1'b0;
          lpbk_q <= 1'b0;
        end
        else
        begin
          swing_q <= swing;
          los_q <= los_en & rx_on_d;
          rx_on_q <= rx_on_d;
          rx_spd_q <= rx_spd_d;
          rx_rsv_q <= rx_rsv_d;
          de_q <= deemph;
          tx_on_q <= tx_on_d;
          tx_spd_q <= tx_spd_d;
          tx_rsv_q <= tx_rsv_d;
          tx_inv_q <= tx_inv;
          rx_inv_q <= rx_inv;
          eq_q <= eq;
          eq_max_q <= eq_max_d;
          eq_step_q <= eq_step_d;
          eq_rsv_q <= eq_rsv_d;
          cdr_2nd_q <= cdr_2nd_d;
          cdr_lowp_q <= cdr_lowp_d;
          cdr_t17_q <= cdr_t17_d;
          cdr_rsv_q <= cdr_rsv_d;
          in_test_q <= in_test;
          out_test_q <= out_test;
          lpbk_q <= in_test & out_test & (far_loopback_select_i != `LSC_LPBK_OFF);
        end
      end

      assign tx_amplitude_code_o[3*g +: 3] = swing_q;
      assign sig_loss_detect_en_o[g] = los_q;
      assign rx_lane_on_o[g] = rx_on_q;
      assign rx_lane_speed_o[2*g +: 2] = rx_spd_q;
      assign rx_speed_reserved_o[g] = rx_rsv_q;
      assign tx_deemph_code_o[4*g +: 4] = de_q;
      assign tx_lane_on_o[g] = tx_on_q;
      assign tx_lane_speed_o[2*g +: 2] = tx_spd_q;
      assign tx_speed_reserved_o[g] = tx_rsv_q;
      assign tx_polarity_swap_o[g] = tx_inv_q;
      assign rx_polarity_swap_o[g] = rx_inv_q;
      assign rx_equalizer_code_o[4*g +: 4] = eq_q;
      assign rx_eq_max_gain_o[g] = eq_max_q;
      assign rx_eq_zero_step_o[3*g +: 3] = eq_step_q;
      assign rx_eq_reserved_o[g] = eq_rsv_q;
      assign cdr_second_order_o[g] = cdr_2nd_q;
      assign cdr_low_precision_o[g] = cdr_lowp_q;
      assign cdr_threshold17_o[g] = cdr_t17_q;
      assign cdr_reserved_o[g] = cdr_rsv_q;
      assign input_side_test_on_o[g] = in_test_q;
      assign output_side_test_on_o[g] = out_test_q;
      assign far_loopback_on_o[g] = lpbk_q;
    end
  endgenerate

  // Read mux: AND-OR over selected lanes, so a non one-hot selector gives merged data
  reg [DATA_W-1:0] rd_mux;
  integer i;

  always @*
  begin
    rd_mux = {DATA_W{1'b0}};
    for (i = 0; i < LANES; i = i + 1)
    begin
      if (lane_select_onehot_i[i])
      begin
        if (hit_drive)
        begin
          rd_mux = rd_mux | drive_all[i*DATA_W +: DATA_W];
        end
        else if (hit_recv)
        begin
          rd_mux = rd_mux | recv_all[i*DATA_W +: DATA_W];
        end
      end
    end
  end

  reg [DATA_W-1:0] rdata_q;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= {DATA_W{1'b0}};
    end
    else
    begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule

// ---- testbench/lsc_top_assertions.sv ----
`timescale 1ns/1ps
module lsc_top_assertions (
  input wire clk_i,
  input wire rst_n_i,
  input wire [4:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  input wire reg_hit_o,
  input wire sel_valid_o,
  input wire [3:0] lane_select_onehot_i,
  input wire ctrl_powerdown_i,
  input wire ser_2to1_mode_i,
  input wire deser_1to2_mode_i,
  input wire [1:0] far_loopback_select_i,
  input wire channel_powerdown_n_i,
  input wire [11:0] tx_amplitude_code_o,
  input wire [3:0] sig_loss_detect_en_o,
  input wire [3:0] rx_lane_on_o,
  input wire [3:0] tx_lane_on_o,
  input wire [15:0] tx_deemph_code_o,
  input wire [15:0] rx_equalizer_code_o,
  input wire [3:0] input_side_test_on_o,
  input wire [3:0] output_side_test_on_o,
  input wire [3:0] far_loopback_on_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_hit_decode: assert property (reg_hit_o == (reg_addr_i == 5'h07 || reg_addr_i == 5'h08))
    else $error("hit decode wrong");
  a_sel_valid: assert property (sel_valid_o == $onehot(lane_select_onehot_i))
    else $error("selector check wrong");
  a_read_empty: assert property ((!reg_hit_o || lane_select_onehot_i == 4'h0) |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero");
  a_write_lane0: assert property (reg_wr_i && reg_addr_i == 5'h07 && lane_select_onehot_i[0] |-> ##2
    tx_amplitude_code_o[2:0] == $past(reg_wdata_i[14:12], 2) &&
    tx_deemph_code_o[3:0] == $past(reg_wdata_i[7:4], 2))
    else $error("lane 0 drive write lost");
  a_recv_lane3: assert property (reg_wr_i && reg_addr_i == 5'h08 && lane_select_onehot_i[3] |-> ##2
    rx_equalizer_code_o[15:12] == $past(reg_wdata_i[11:8], 2) &&
    input_side_test_on_o[3] == $past(reg_wdata_i[3], 2))
    else $error("lane 3 receive write lost");
  a_keep_other: assert property ($past(rst_n_i) && reg_wr_i && !lane_select_onehot_i[1] |-> ##2
    $stable(tx_amplitude_code_o[5:3]) && $stable(rx_equalizer_code_o[7:4]))
    else $error("unselected lane changed");
  a_rx_upper: assert property (ser_2to1_mode_i |=> rx_lane_on_o[3:2] == 2'b00)
    else $error("upper inputs on in 2:1");
  a_tx_upper: assert property (deser_1to2_mode_i |=> tx_lane_on_o[3:2] == 2'b00)
    else $error("upper outputs on in 1:2");
  a_ctrl_pd: assert property (ctrl_powerdown_i |=> (rx_lane_on_o | tx_lane_on_o) == 4'h0)
    else $error("lanes on under control power-down");
  a_pin_pd: assert property (!channel_powerdown_n_i |-> ##3 (rx_lane_on_o | tx_lane_on_o) == 4'h0)
    else $error("lanes on under pin power-down");
  a_los_gate: assert property ((sig_loss_detect_en_o & ~rx_lane_on_o) == 4'h0)
    else $error("loss detect on a disabled input");
  a_loop_off: assert property (far_loopback_select_i == 2'b00 |=> far_loopback_on_o == 4'h0)
    else $error("far loopback without control");
  a_loop_tests: assert property ((far_loopback_on_o & ~(input_side_test_on_o & output_side_test_on_o)) == 4'h0)
    else $error("far loopback without test bits");
endmodule
bind lsc_top lsc_top_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
  .sel_valid_o(sel_valid_o), .lane_select_onehot_i(lane_select_onehot_i), .ctrl_powerdown_i(ctrl_powerdown_i),
  .ser_2to1_mode_i(ser_2to1_mode_i), .deser_1to2_mode_i(deser_1to2_mode_i),
  .far_loopback_select_i(far_loopback_select_i), .channel_powerdown_n_i(channel_powerdown_n_i),
  .tx_amplitude_code_o(tx_amplitude_code_o), .sig_loss_detect_en_o(sig_loss_detect_en_o),
  .rx_lane_on_o(rx_lane_on_o), .tx_lane_on_o(tx_lane_on_o), .tx_deemph_code_o(tx_deemph_code_o),
  .rx_equalizer_code_o(rx_equalizer_code_o), .input_side_test_on_o(input_side_test_on_o),
  .output_side_test_on_o(output_side_test_on_o), .far_loopback_on_o(far_loopback_on_o));

// ---- testbench/lsc_station_model.sv ----
`timescale 1ns/1ps
// Management station: one register access at a time, bus parked off the bank between accesses
module lsc_station_model (
  input wire clk_i,
  input wire [15:0] rdata_i,
  output reg [4:0] addr_o,
  output reg wr_o,
  output reg [15:0] wdata_o,
  output reg [3:0] sel_o
);
  initial
  begin
    addr_o = 5'h1F;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
    sel_o = 4'h1;
  end
  task wr(input [4:0] a, input [3:0] s, input [15:0] w);
    @(posedge clk_i);
    #1;
    addr_o = a;
    sel_o = s;
    wdata_o = w;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~w;
    addr_o = 5'h1F;
  endtask
  task rd(input [4:0] a, input [3:0] s, output [15:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    sel_o = s;
    @(posedge clk_i);
    #1;
    d = rdata_i;
    addr_o = 5'h1F;
  endtask
endmodule

// ---- testbench/lowside_serdes_lane_config_bench.sv ----
`timescale 1ns/1ps
module lowside_serdes_lane_config_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ser = 1'b0, deser = 1'b0, ctrl_pd = 1'b0, pin_n = 1'b1;
  logic [1:0] lp = 2'b00;
  logic [31:0] rv;
  logic [15:0] rd_v;
  logic [15:0] sd [4];
  logic [15:0] sr [4];
  wire [4:0] addr;
  wire wr, hit, selv;
  wire [15:0] wdata, rdata, de, eq;
  wire [11:0] amp, zs;
  wire [7:0] rxs, txs;
  wire [3:0] sel, los, rxon, txon, rxr, txr, txp, rxp, eqmax, cr, its, ots, flb, eqr, c2, clp, c17;
  integer seed = 60, mismatches = 0, checks = 0, i, g, l;
  always #10 clk_i = ~clk_i;
  lsc_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_hit_o(hit), .sel_valid_o(selv), .lane_select_onehot_i(sel),
    .ctrl_powerdown_i(ctrl_pd), .ser_2to1_mode_i(ser), .deser_1to2_mode_i(deser), .far_loopback_select_i(lp),
    .channel_powerdown_n_i(pin_n), .tx_amplitude_code_o(amp), .sig_loss_detect_en_o(los), .rx_lane_on_o(rxon),
    .rx_lane_speed_o(rxs), .rx_speed_reserved_o(rxr), .tx_deemph_code_o(de), .tx_lane_on_o(txon),
    .tx_lane_speed_o(txs), .tx_speed_reserved_o(txr), .tx_polarity_swap_o(txp), .rx_polarity_swap_o(rxp),
    .rx_equalizer_code_o(eq), .rx_eq_max_gain_o(eqmax), .rx_eq_zero_step_o(zs), .rx_eq_reserved_o(eqr),
    .cdr_second_order_o(c2), .cdr_low_precision_o(clp), .cdr_threshold17_o(c17), .cdr_reserved_o(cr),
    .input_side_test_on_o(its), .output_side_test_on_o(ots), .far_loopback_on_o(flb));
  lsc_station_model ST (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .sel_o(sel));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function [31:0] lane_view(input integer k);
    lane_view = {amp[3*k+:3], de[4*k+:4], rxon[k], txon[k], los[k], rxs[2*k+:2], txs[2*k+:2], rxr[k], txr[k],
      txp[k], rxp[k], eq[4*k+:4], eqmax[k], cr[k], its[k], ots[k], flb[k]};
  endfunction
  function [31:0] exp_lane(input [15:0] d, input [15:0] r, input integer k);
    logic on_r, on_t;
    on_r = d[10] & ~ctrl_pd & pin_n & ~(ser & (k > 1));
    on_t = d[2] & ~ctrl_pd & pin_n & ~(deser & (k > 1));
    exp_lane = {d[14:12], d[7:4], on_r, on_t, d[11] & on_r, (d[9:8] == 2'b11) ? 2'b00 : d[9:8],
      d[1] ? 2'b00 : d[1:0], d[9:8] == 2'b11, d[1], r[15], r[14], r[11:8], r[11:8] == 4'h0,
      r[6:5] == 2'b11, r[3], r[2], r[3] & r[2] & (lp != 2'b00)};
  endfunction
  // Loop mode as {second order, low precision, threshold 17}; equalizer as {zero step, reserved}
  function [6:0] exp_dec(input [15:0] r);
    logic [2:0] cd;
    case (r[6:4])
      3'h1: cd = 3'b001;
      3'h2: cd = 3'b100;
      3'h3: cd = 3'b101;
      3'h4: cd = 3'b010;
      3'h5: cd = 3'b111;
      default: cd = 3'b000;
    endcase
    exp_dec = {r[11] ? r[10:8] : 3'h0, ~r[11] & (r[10:8] != 3'h0), cd};
  endfunction
  task check_lanes;
    for (g = 0; g < 4; g++)
    begin
      chk("lane outputs", lane_view(g), exp_lane(sd[g], sr[g], g));
      chk("lane decodes", {zs[3*g+:3], eqr[g], c2[g], clp[g], c17[g]}, exp_dec(sr[g]));
    end
  endtask
  task check_regs;
    for (g = 0; g < 4; g++)
    begin
      ST.rd(5'h07, 4'h1 << g, rd_v);
      chk("drive word", rd_v, sd[g]);
      ST.rd(5'h08, 4'h1 << g, rd_v);
      chk("receive word", rd_v, sr[g]);
    end
  endtask
  task do_reset(input integer n);
    rst_n_i = 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    for (g = 0; g < 4; g++)
    begin
      sd[g] = 16'hDC04;
      sr[g] = 16'h0001;
    end
    repeat (4) @(posedge clk_i);
    #1;
    check_lanes;
    check_regs;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    conclude;
  end
  initial
  begin
    do_reset(8);
    // Writes with an empty selector or to a foreign address must leave every lane alone
    ST.wr(5'h07, 4'h0, 16'h8000);
    ST.wr(5'h09, 4'hF, 16'h8000);
    ST.rd(5'h09, 4'h1, rd_v);
    chk("foreign read", rd_v, 32'h0);
    check_regs;
    for (i = 0; i < 40; i++)
    begin
      l = $unsigned($random(seed)) % 4;
      rv = $random(seed);
      sd[l] = (rv[15:0] | 16'h8000) & 16'hFFF7;
      rv = $random(seed);
      sr[l] = (rv[15:0] & 16'hCF7C) | 16'h0001;
      ST.wr(5'h07, 4'h1 << l, sd[l]);
      ST.wr(5'h08, 4'h1 << l, sr[l]);
      rv = $random(seed);
      {ser, deser, ctrl_pd, lp} = rv[4:0];
      repeat (2) @(posedge clk_i);
      #1;
      check_lanes;
    end
    check_regs;
    {ser, deser, ctrl_pd, lp} = 5'h00;
    pin_n = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check_lanes;
    pin_n = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check_lanes;
    do_reset(2);
    conclude;
  end
endmodule
